// >>> pei_event_irq.sv
// Event flags, enables and two active-low interrupt lines
`timescale 1ns/1ps
module pei_event_irq
    import pei_pkg::*;
#(
    parameter bit FUND_IDLE_EN = 1'b1,
    parameter bit REACTIVE_EN = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Event pulses per phase
    input wire pei_evt_t evt,
    // Enable registers held by the serial port
    input wire logic [31:0] event_enable_0,
    input wire logic [31:0] event_enable_1,
    // Flag write-back: one bit clears
    input wire logic wr_flags_0,
    input wire logic wr_flags_1,
    input wire logic [31:0] wr_data,
    // Flag registers for reading
    output logic [31:0] event_flags_0,
    output logic [31:0] event_flags_1,
    // Interrupt lines, active low
    output logic event_line_0_n,
    output logic event_line_1_n
);
    // Width check: the bit map below assumes 32-bit flag and enable banks
    if (PEI_W != 32) begin : g_bad_width
        $error("pei_event_irq: width must be 32");
    end

    // Registered and next state
    pei_state_t s_q, s_d;
    // Summary set masks for this cycle
    logic [31:0] set_0, set_1;
    // Effective enable for line 1
    logic [31:0] en_1_eff;

    // Build set vectors from event pulses
    always_comb begin
        set_0 = '0;
        set_1 = '0;
        set_1[PEI_B_TOT_IDLE] = |evt.tot_idle;
        set_1[PEI_B_FUND_IDLE] = FUND_IDLE_EN & (|evt.fund_idle);
        set_1[PEI_B_APP_IDLE] = |evt.app_idle;
        set_1[PEI_B_DIP] = |evt.dip;
        set_1[PEI_B_HI_CUR] = |evt.hi_cur;
        set_1[PEI_B_HI_VOLT] = |evt.hi_volt;
        set_1[PEI_B_PK_CUR] = |evt.pk_cur;
        set_1[PEI_B_PK_VOLT] = |evt.pk_volt;
        set_0[PEI_B_ACT_REV_LO +: 3] = evt.act_rev;
        set_0[PEI_B_REA_REV_LO +: 3] = REACTIVE_EN ? evt.rea_rev : 3'h0;
        set_0[PEI_B_SUM_REV_0] = evt.sum_rev[0];
        set_0[PEI_B_SUM_REV_1] = evt.sum_rev[1];
        set_0[PEI_B_SUM_REV_2] = evt.sum_rev[2];
        // reset complete on first clock after release
        set_1[PEI_B_RST_DONE] = ~s_q.rst_seen;
    end

    // Next state: clear by write-one, set wins over clear
    always_comb begin
        s_d = s_q;
        s_d.rst_seen = 1'b1;
        if (wr_flags_0) begin
            s_d.flags_0 = s_d.flags_0 & ~wr_data;
        end
        if (wr_flags_1) begin
            s_d.flags_1 = s_d.flags_1 & ~wr_data;
        end
        s_d.flags_0 = s_d.flags_0 | set_0;
        s_d.flags_1 = s_d.flags_1 | set_1;
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{flags_0: PEI_FLAG_RST, flags_1: PEI_FLAG_RST,
                     rst_seen: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // enables are zero after reset outside
    always_comb begin
        en_1_eff = event_enable_1;
        en_1_eff[PEI_B_RST_DONE] = 1'b1;
    end

    assign event_flags_0 = s_q.flags_0;
    assign event_flags_1 = s_q.flags_1;
    assign event_line_0_n = ~|(s_q.flags_0 & event_enable_0);
    assign event_line_1_n = ~|(s_q.flags_1 & en_1_eff);

    // Assertions
    // Any phase dip lands in its summary flag one cycle later
    property p_set_any;
        @(posedge clock) disable iff (!rstn)
        (|evt.dip) |=> event_flags_1[PEI_B_DIP];
    endproperty
    a_set_any: assert property (p_set_any) else $error("dip flag missed");

    // Apparent idle summary follows any phase
    property p_idle;
        @(posedge clock) disable iff (!rstn)
        (|evt.app_idle) |=> event_flags_1[PEI_B_APP_IDLE];
    endproperty
    a_idle: assert property (p_idle) else $error("idle flag missed");

    // Voltage peak summary follows any phase
    property p_peak;
        @(posedge clock) disable iff (!rstn)
        (|evt.pk_volt) |=> event_flags_1[PEI_B_PK_VOLT];
    endproperty
    a_peak: assert property (p_peak) else $error("peak flag missed");

    // Phase C active reversal keeps its own bit position
    property p_rev;
        @(posedge clock) disable iff (!rstn)
        evt.act_rev[2] |=> event_flags_0[PEI_B_ACT_REV_LO + 2];
    endproperty
    a_rev: assert property (p_rev) else $error("reversal flag missed");

    // A one written with no new event clears the flag
    property p_clear;
        @(posedge clock) disable iff (!rstn)
        (wr_flags_1 && wr_data[PEI_B_HI_CUR] && !(|evt.hi_cur))
            |=> !event_flags_1[PEI_B_HI_CUR];
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    // Without a write a flag never drops
    property p_keep;
        @(posedge clock) disable iff (!rstn)
        (event_flags_0[PEI_B_SUM_REV_2] && !wr_flags_0)
            |=> event_flags_0[PEI_B_SUM_REV_2];
    endproperty
    a_keep: assert property (p_keep) else $error("flag lost");

    // Enabled flag pulls line 0 low in the same cycle
    property p_line;
        @(posedge clock) disable iff (!rstn)
        (event_flags_0[PEI_B_ACT_REV_LO + 2] &&
            event_enable_0[PEI_B_ACT_REV_LO + 2])
            |-> !event_line_0_n;
    endproperty
    a_line: assert property (p_line) else $error("line 0 not low");

    // Nothing enabled and no reset-complete: line 1 must be released
    property p_high;
        @(posedge clock) disable iff (!rstn)
        (!event_flags_1[PEI_B_RST_DONE] &&
            ((event_flags_1 & event_enable_1) == 32'h0000_0000))
            |-> event_line_1_n;
    endproperty
    a_high: assert property (p_high) else $error("line 1 stuck low");

    // First edge after reset raises reset-complete
    property p_rst;
        @(posedge clock) disable iff (!rstn)
        !s_q.rst_seen |=> event_flags_1[PEI_B_RST_DONE] && !event_line_1_n;
    endproperty
    a_rst: assert property (p_rst) else $error("reset done missing");

    // Enabled voltage peak pulls line 1 low
    property p_line1;
        @(posedge clock) disable iff (!rstn)
        (event_flags_1[PEI_B_PK_VOLT] && event_enable_1[PEI_B_PK_VOLT])
            |-> !event_line_1_n;
    endproperty
    a_line1: assert property (p_line1) else $error("line 1 not low");

    // Phase C sum reversal lands at its even position
    property p_sum;
        @(posedge clock) disable iff (!rstn)
        evt.sum_rev[2] |=> event_flags_0[PEI_B_SUM_REV_2];
    endproperty
    a_sum: assert property (p_sum) else $error("sum flag missed");

    // Reset-complete holds line 1 low whatever the enables say
    property p_hold;
        @(posedge clock) disable iff (!rstn)
        event_flags_1[PEI_B_RST_DONE] |-> !event_line_1_n;
    endproperty
    a_hold: assert property (p_hold) else $error("reset done masked");

    // Write-back on bank 0 clears a flag with no new event
    property p_clr0;
        @(posedge clock) disable iff (!rstn)
        (wr_flags_0 && wr_data[PEI_B_SUM_REV_2] && !evt.sum_rev[2])
            |=> !event_flags_0[PEI_B_SUM_REV_2];
    endproperty
    a_clr0: assert property (p_clr0) else $error("bank 0 clear failed");

    // Main scenarios: line falls, line releases, set meets clear
    c_line0: cover property (@(posedge clock) disable iff (!rstn)
        $fell(event_line_0_n));
    c_clr1: cover property (@(posedge clock) disable iff (!rstn)
        $rose(event_line_1_n));
    c_race: cover property (@(posedge clock) disable iff (!rstn)
        wr_flags_1 && wr_data[PEI_B_DIP] && (|evt.dip));
    // Both lines low at once
    c_both: cover property (@(posedge clock) disable iff (!rstn)
        !event_line_0_n && !event_line_1_n);
endmodule // pei_event_irq

// >>> pei_pkg.sv
// Package for the phase event interrupt logic: field positions and resets
package pei_pkg;
    // Flag and enable register width
    localparam int PEI_W = 32;
    // Second bank: idle summary flags
    localparam int PEI_B_TOT_IDLE = 0;
    localparam int PEI_B_FUND_IDLE = 1;
    localparam int PEI_B_APP_IDLE = 2;
    // Second bank: reset complete, never masked
    localparam int PEI_B_RST_DONE = 15;
    // Second bank: dip, high current, high voltage
    localparam int PEI_B_DIP = 16;
    localparam int PEI_B_HI_CUR = 17;
    localparam int PEI_B_HI_VOLT = 18;
    // Second bank: peak captures
    localparam int PEI_B_PK_CUR = 23;
    localparam int PEI_B_PK_VOLT = 24;
    // First bank: power reversal fields
    localparam int PEI_B_ACT_REV_LO = 6;
    localparam int PEI_B_REA_REV_LO = 10;
    localparam int PEI_B_SUM_REV_0 = 9;
    localparam int PEI_B_SUM_REV_1 = 13;
    localparam int PEI_B_SUM_REV_2 = 18;
    // Reset values
    localparam logic [31:0] PEI_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] PEI_FLAG_RST = 32'h0000_0000;

    // Per-phase detail destined for the secondary registers
    typedef struct packed {
        logic [2:0] tot_idle;
        logic [2:0] fund_idle;
        logic [2:0] app_idle;
        logic [2:0] dip;
        logic [2:0] hi_cur;
        logic [2:0] hi_volt;
        logic [2:0] pk_cur;
        logic [2:0] pk_volt;
        logic [2:0] act_rev;
        logic [2:0] rea_rev;
        logic [2:0] sum_rev;
    } pei_evt_t;

    // Whole module state
    typedef struct packed {
        logic [31:0] flags_0;
        logic [31:0] flags_1;
        logic rst_seen;
    } pei_state_t;
endpackage

// >>> pei_host_model.sv
// Host model that services both interrupt lines by read and write-back
`timescale 1ns/1ps
module pei_host_model (
    // Clock, reset, service enable
    input wire logic clock,
    input wire logic rstn,
    input wire logic svc_en,
    // Device side
    input wire logic line_0_n,
    input wire logic line_1_n,
    input wire logic [31:0] flags_0,
    input wire logic [31:0] flags_1,
    output logic wr_0,
    output logic wr_1,
    output logic [31:0] wdata
);
    // Edge detect history and latched pending edges
    logic prev_0, prev_1, pend_0, pend_1;
    // Strobes last one cycle, then an edge passes before the next one
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // History idles high like the lines, nothing pending
            {prev_0, prev_1, pend_0, pend_1} <= 4'hC;
            {wr_0, wr_1} <= 2'b00;
            wdata <= 32'h0000_0000;
        end else begin
            prev_0 <= line_0_n;
            prev_1 <= line_1_n;
            wr_0 <= 1'b0;
            wr_1 <= 1'b0;
            if (prev_0 && !line_0_n) pend_0 <= 1'b1;
            if (prev_1 && !line_1_n) pend_1 <= 1'b1;
            if (svc_en && !wr_0 && !wr_1) begin
                if (pend_1 || !line_1_n) begin
                    wr_1 <= 1'b1;
                    wdata <= flags_1;
                    pend_1 <= 1'b0;
                end else if (pend_0 || !line_0_n) begin
                    wr_0 <= 1'b1;
                    wdata <= flags_0;
                    pend_0 <= 1'b0;
                end
            end
        end
    end
endmodule // pei_host_model

// >>> pei_event_irq_bench.sv
// Self-checking bench for the event flag and interrupt line logic
`timescale 1ns/1ps
module pei_event_irq_bench;
    import pei_pkg::*;
    logic clock, rstn, svc_en, w0, w1, l0_n, l1_n;
    pei_evt_t evt;
    logic [31:0] en_0, en_1, wd, f0, f1;
    int fail_count, comparisons, cycles;
    pei_event_irq pei_event_irq_i (.clock(clock), .rstn(rstn), .evt(evt),
        .event_enable_0(en_0), .event_enable_1(en_1), .wr_flags_0(w0),
        .wr_flags_1(w1), .wr_data(wd), .event_flags_0(f0),
        .event_flags_1(f1), .event_line_0_n(l0_n), .event_line_1_n(l1_n));
    pei_host_model pei_host_model_i (.clock(clock), .rstn(rstn),
        .svc_en(svc_en), .line_0_n(l0_n), .line_1_n(l1_n), .flags_0(f0),
        .flags_1(f1), .wr_0(w0), .wr_1(w1), .wdata(wd));
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            test_done();
        end
    end
    // One-cycle event pulse, flags sampled after landing
    task automatic pulse(input pei_evt_t e);
        @(posedge clock) #1 evt = e;
        @(posedge clock) #1 evt = '0;
    endtask
    // Let the host service, bounded wait for empty flags
    task automatic serve();
        svc_en = 1'b1;
        for (int i = 0; i < 12 && (f0 !== 0 || f1 !== 0); i++)
            @(posedge clock) #1;
        svc_en = 1'b0;
        chk(f0, 32'h0000_0000);
        chk(f1, 32'h0000_0000);
        chk({l0_n, l1_n}, 32'h0000_0003);
    endtask
    task automatic t_reset();
        chk(f1, 32'h0000_8000);
        chk({l0_n, l1_n}, 32'h0000_0002);
        serve();
    endtask
    task automatic t_masked();
        pei_evt_t e;
        e = '0;
        e.dip = 3'b010;
        pulse(e);
        chk(f1, 32'h0001_0000);
        chk(l1_n, 32'h0000_0001);
        en_1 = 32'h0001_0000;
        #1 chk(l1_n, 32'h0000_0000);
        serve();
        en_1 = 32'h0000_0000;
    endtask
    task automatic t_banks();
        pei_evt_t e;
        e = '0;
        e.act_rev = 3'b101;
        e.rea_rev = 3'b010;
        e.sum_rev = 3'b111;
        e.tot_idle = 3'b001;
        e.fund_idle = 3'b100;
        e.app_idle = 3'b010;
        {e.hi_cur, e.hi_volt, e.pk_cur, e.pk_volt} = 12'h249;
        pulse(e);
        chk(f0, 32'h0004_2B40);
        chk(f1, 32'h0186_0007);
        en_0 = 32'h0000_0100;
        en_1 = 32'h0100_0000;
        #1 chk({l0_n, l1_n}, 32'h0000_0000);
        serve();
        en_0 = 32'h0000_0000;
        en_1 = 32'h0000_0000;
    endtask
    // Event still high when the host clears: the set must win
    task automatic t_race();
        pei_evt_t e;
        e = '0;
        e.dip = 3'b001;
        @(posedge clock) #1;
        en_1 = 32'h0001_0000;
        svc_en = 1'b1;
        evt = e;
        repeat (3) @(posedge clock);
        #1 evt = '0;
        chk(f1, 32'h0001_0000);
        serve();
        en_1 = 32'h0000_0000;
    endtask
    // Reset in mid-run: flags drop, reset-complete returns
    task automatic t_rerst();
        @(posedge clock) #1 rstn = 1'b0;
        #1 chk(f1, 32'h0000_0000);
        chk({l0_n, l1_n}, 32'h0000_0003);
        repeat (2) @(posedge clock);
        #1 rstn = 1'b1;
        @(posedge clock) #1;
        chk(f1, 32'h0000_8000);
        chk({l0_n, l1_n}, 32'h0000_0002);
        serve();
    endtask
    // Main sequence
    initial begin
        {rstn, svc_en, evt, en_0, en_1} = '0;
        {fail_count, comparisons, cycles} = '0;
        repeat (2) @(posedge clock);
        #1 rstn = 1'b1;
        @(posedge clock) #1;
        t_reset();
        t_masked();
        t_banks();
        t_race();
        t_rerst();
        test_done();
    end
endmodule // pei_event_irq_bench
